// file: sac_conv_ctrl.sv
`timescale 1ns/1ns
`include "sac_consts.svh"

module sac_conv_ctrl (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  // Control/status register access
  input  wire logic                  csr_wr,
  input  wire logic [7:0]            csr_wdata,
  input  wire logic                  result_high_rd,
  // Power mode
  input  wire logic                  halt_mode,
  // Analog front end
  input  wire logic                  cmp_above,
  input  wire logic                  above_high_reference,
  input  wire logic                  below_low_reference,
  // Control/status fields
  output logic                       conv_complete_q,
  output logic                       speed_q,
  output logic                       converter_on_q,
  output logic [`SAC_CHAN_W-1:0]     channel_select_q,
  // Result bytes
  output logic [7:0]                 result_high_byte_q,
  output logic [7:0]                 result_low_byte_q,
  // Converter drive
  output logic [`SAC_CHAN_N-1:0]     analog_input_select_q,
  output logic                       sample_hold_q,
  output logic                       converter_power_q,
  output logic [`SAC_RES_W-1:0]      dac_code_q
);

  // =====================================================
  // Channel decode
  function automatic logic [`SAC_CHAN_N-1:0] sac_chan_decode(input logic [`SAC_CHAN_W-1:0] idx);
    logic [`SAC_CHAN_N-1:0] sel;
    sel = `SAC_SEL_RST;
    sel[idx] = 1'b1;
    return sel;
  endfunction : sac_chan_decode

  // =====================================================
  // Internal signals
  sac_pkg::sac_state_e   state_q;
  logic [1:0]            samp_cnt_q;
  logic                  run;
  logic                  chan_change;
  logic                  restart;
  logic                  tick;
  logic                  sar_start;
  logic                  sar_abort;
  logic                  sar_done;
  logic [`SAC_RES_W-1:0] sar_result;
  logic [`SAC_CHAN_W-1:0] new_chan;
  logic                  new_on;

  assign new_chan    = csr_wdata[`SAC_CSR_CHAN_HI:`SAC_CSR_CHAN_LO];
  assign new_on      = csr_wdata[`SAC_CSR_ON];
  // Wait mode has no input here: conversion carries on
  assign run         = converter_on_q && !halt_mode; // RQ14 RQ15
  assign chan_change = csr_wr && (new_chan != channel_select_q); // RQ12
  assign restart     = chan_change && converter_on_q;
  assign sar_abort   = restart || !run; // RQ12 RQ13
  assign sar_start   = (state_q == sac_pkg::SAC_SAMPLE) && tick && (samp_cnt_q == `SAC_SAMPLE_LAST) && !sar_abort;

  // =====================================================
  // Converter clock divider
  sac_tick_gen u_tick (
    .ref_clk (ref_clk),
    .reset   (reset),
    .enable  (run && !restart),
    .speed   (speed_q),
    .tick_q  (tick)
  );

  // =====================================================
  // Successive approximation core
  sac_sar_core u_sar (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .start      (sar_start),
    .abort      (sar_abort),
    .step       (tick),
    .cmp_above  (cmp_above),
    .force_high (above_high_reference),
    .force_low  (below_low_reference),
    .dac_code_q (dac_code_q),
    .result_q   (sar_result),
    .done_q     (sar_done)
  );

  // =====================================================
  // Control/status fields
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      speed_q          <= 1'b0;
      converter_on_q   <= 1'b0; // RQ21
      channel_select_q <= `SAC_CHAN_RST;
    end else if (csr_wr) begin
      speed_q          <= csr_wdata[`SAC_CSR_SPEED];
      converter_on_q   <= new_on; // RQ5 RQ13
      channel_select_q <= new_chan;
    end
  end

  // =====================================================
  // Completion flag, set wins over clear except when a channel-change restart clears it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      conv_complete_q <= 1'b0;
    end else if (sar_done && !restart) begin
      conv_complete_q <= 1'b1; // RQ7
    end else if (csr_wr || result_high_rd) begin
      conv_complete_q <= 1'b0; // RQ8 RQ18 RQ12
    end
  end

  // =====================================================
  // Result bytes, overwritten on every completion not coinciding with a restart
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      result_high_byte_q <= `SAC_BYTE_RST;
      result_low_byte_q  <= `SAC_BYTE_RST;
    end else if (sar_done && !restart) begin
      result_high_byte_q <= sar_result[9:2]; // RQ19 RQ10
      result_low_byte_q  <= {`SAC_LOW_PAD, sar_result[1:0]}; // RQ19
    end
  end

  // =====================================================
  // Input multiplexer and power
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      analog_input_select_q <= `SAC_SEL_RST;
      converter_power_q     <= 1'b0;
    end else begin
      analog_input_select_q <= run ? sac_chan_decode(channel_select_q) : `SAC_SEL_RST; // RQ2 RQ17
      converter_power_q     <= run; // RQ5 RQ13 RQ15
    end
  end

  // =====================================================
  // Conversion sequencer
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q    <= sac_pkg::SAC_IDLE;
      samp_cnt_q <= 2'h0;
    end else if (!run) begin
      state_q    <= sac_pkg::SAC_IDLE; // RQ13
      samp_cnt_q <= 2'h0;
    end else if (restart) begin
      state_q    <= sac_pkg::SAC_SAMPLE; // RQ12
      samp_cnt_q <= 2'h0;
    end else begin
      unique case (state_q)
        sac_pkg::SAC_IDLE: begin
          state_q    <= sac_pkg::SAC_SAMPLE; // RQ5
          samp_cnt_q <= 2'h0;
        end
        sac_pkg::SAC_SAMPLE: begin
          if (sar_start) begin
            state_q <= sac_pkg::SAC_CONVERT; // RQ20
          end else if (tick) begin
            samp_cnt_q <= samp_cnt_q + 2'h1;
          end
        end
        sac_pkg::SAC_CONVERT: begin
          if (sar_done) begin
            state_q    <= sac_pkg::SAC_SAMPLE; // RQ6
            samp_cnt_q <= 2'h0;
          end
        end
        default: begin
          state_q    <= sac_pkg::SAC_IDLE;
          samp_cnt_q <= 2'h0;
        end
      endcase
    end
  end

  // =====================================================
  // Sample and hold drive
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sample_hold_q <= 1'b0;
    end else begin
      sample_hold_q <= run && !restart && (state_q == sac_pkg::SAC_SAMPLE) && !sar_start; // RQ20
    end
  end

  // =====================================================
  // Checks
  chk_done_sets_flag : assert property (@(posedge ref_clk) disable iff (reset) // RQ7
    (sar_done && !restart) |=> conv_complete_q)
    else $error("Completion did not set flag");

  chk_result_bytes : assert property (@(posedge ref_clk) disable iff (reset) // RQ19
    (sar_done && !restart) |=> (result_high_byte_q == $past(sar_result[9:2])
      && result_low_byte_q[1:0] == $past(sar_result[1:0])))
    else $error("Result bytes not updated");

  chk_low_pad_zero : assert property (@(posedge ref_clk) disable iff (reset) // RQ19
    result_low_byte_q[7:2] == `SAC_LOW_PAD)
    else $error("Low byte upper bits not zero");

  chk_high_read_clear : assert property (@(posedge ref_clk) disable iff (reset) // RQ8
    (result_high_rd && !sar_done) |=> !conv_complete_q)
    else $error("High read did not clear flag");

  chk_csr_write_clear : assert property (@(posedge ref_clk) disable iff (reset) // RQ18
    (csr_wr && !sar_done) |=> !conv_complete_q)
    else $error("Control write did not clear flag");

  chk_chan_restart : assert property (@(posedge ref_clk) disable iff (reset) // RQ12
    (restart && new_on && !halt_mode) |=> (state_q == sac_pkg::SAC_SAMPLE && samp_cnt_q == 2'h0
      && !conv_complete_q))
    else $error("Channel change did not restart");

  chk_off_powers_down : assert property (@(posedge ref_clk) disable iff (reset) // RQ13
    !run |=> (!converter_power_q && state_q == sac_pkg::SAC_IDLE && analog_input_select_q == `SAC_SEL_RST))
    else $error("Converter not stopped");

  chk_mux_select : assert property (@(posedge ref_clk) disable iff (reset) // RQ17
    run |=> analog_input_select_q == sac_chan_decode($past(channel_select_q)))
    else $error("Wrong input selected");

  chk_continuous : assert property (@(posedge ref_clk) disable iff (reset) // RQ6
    (sar_done && run && !restart) |=> ##[1:16] (sar_start || sar_abort))
    else $error("Next conversion did not start");

  chk_conv_length : assert property (@(posedge ref_clk) disable iff (reset) // RQ20
    sar_start |=> ##[19:44] (sar_done || sar_abort))
    else $error("Conversion length out of range");

  chk_reset_state : assert property (@(posedge ref_clk) // RQ21
    reset |=> (!converter_on_q && !conv_complete_q && channel_select_q == `SAC_CHAN_RST
      && result_high_byte_q == `SAC_BYTE_RST && result_low_byte_q == `SAC_BYTE_RST))
    else $error("Reset values wrong");

  chk_on_powers_up : assert property (@(posedge ref_clk) disable iff (reset) // RQ5
    (csr_wr && new_on) ##1 !halt_mode |=> converter_power_q)
    else $error("Converter not powered after enable");

  chk_halt_stops : assert property (@(posedge ref_clk) disable iff (reset) // RQ15
    halt_mode |=> (!converter_power_q && !sample_hold_q))
    else $error("Halt did not stop converter");

  chk_power_source : assert property (@(posedge ref_clk) disable iff (reset) // RQ13
    converter_power_q |-> ($past(converter_on_q) && !$past(halt_mode)))
    else $error("Converter powered while off");

  chk_mux_one_hot : assert property (@(posedge ref_clk) disable iff (reset) // RQ2
    converter_power_q |-> $onehot(analog_input_select_q))
    else $error("Input select not one hot");

  chk_select_off_idle : assert property (@(posedge ref_clk) disable iff (reset) // RQ13
    !converter_power_q |-> analog_input_select_q == `SAC_SEL_RST)
    else $error("Input selected while powered down");

  chk_hold_off_power : assert property (@(posedge ref_clk) disable iff (reset) // RQ13
    !converter_power_q |-> !sample_hold_q)
    else $error("Sampling while powered down");

  chk_tick_stopped : assert property (@(posedge ref_clk) disable iff (reset) // RQ13
    !run |=> !tick)
    else $error("Converter clock runs while stopped");

  chk_abort_clears : assert property (@(posedge ref_clk) disable iff (reset) // RQ12
    restart |=> (!sar_done && dac_code_q == `SAC_RES_RST))
    else $error("Restart did not abort conversion");

  chk_fields_hold : assert property (@(posedge ref_clk) disable iff (reset) // RQ12
    !csr_wr |=> ($stable(channel_select_q) && $stable(converter_on_q)))
    else $error("Control fields changed without write");

  chk_flag_holds : assert property (@(posedge ref_clk) disable iff (reset) // RQ7
    (conv_complete_q && !csr_wr && !result_high_rd) |=> conv_complete_q)
    else $error("Completion flag lost");

  chk_flag_source : assert property (@(posedge ref_clk) disable iff (reset) // RQ7
    $rose(conv_complete_q) |-> ($past(sar_done) && !$past(restart)))
    else $error("Completion flag set without completion");

  chk_results_stable : assert property (@(posedge ref_clk) disable iff (reset) // RQ10
    !(sar_done && !restart) |=> ($stable(result_high_byte_q) && $stable(result_low_byte_q)))
    else $error("Result bytes changed without completion");

  chk_done_in_convert : assert property (@(posedge ref_clk) disable iff (reset) // RQ6
    sar_done |-> state_q == sac_pkg::SAC_CONVERT)
    else $error("Completion outside conversion");

  chk_next_sample : assert property (@(posedge ref_clk) disable iff (reset) // RQ6
    (sar_done && run && !restart) |=> state_q == sac_pkg::SAC_SAMPLE)
    else $error("No sample phase after completion");

  chk_start_leaves_sample : assert property (@(posedge ref_clk) disable iff (reset) // RQ20
    sar_start |=> (state_q == sac_pkg::SAC_CONVERT && !sample_hold_q))
    else $error("Sampling continued into conversion");

  chk_hold_in_convert : assert property (@(posedge ref_clk) disable iff (reset) // RQ20
    state_q != sac_pkg::SAC_SAMPLE |-> !sample_hold_q)
    else $error("Sampling outside sample phase");

  chk_msb_first : assert property (@(posedge ref_clk) disable iff (reset) // RQ20
    sar_start |=> dac_code_q == `SAC_RES_MSB_CODE)
    else $error("First trial code wrong");

endmodule : sac_conv_ctrl

// file: sac_consts.svh
// Function
// (RQ1) Each conversion yields a ten-bit unsigned result read as high and low bytes.
// (RQ2) A multiplexer selects one of up to sixteen analog inputs.
// (RQ3) Input above high reference saturates to high FFh, low 03h, no overflow flag.
// (RQ4) Input below low reference gives zero in both result bytes.
// (RQ5) Setting converter_on powers the converter and starts converting the selected channel.
// (RQ6) While converter_on stays set, conversions repeat back to back.
// (RQ7) Each completed conversion updates both result bytes and sets the completion flag.
// (RQ8) Reading the high result byte clears the completion flag.
// (RQ9) Software polls the flag, reads the low byte, then the high byte.
// (RQ10) Results are overwritten on completion; software reads both bytes before the next.
// (RQ11) For eight bits software polls the flag then reads only the high byte.
// (RQ12) Changing channel_select aborts the conversion, clears the flag, restarts on new channel.
// (RQ13) Clearing converter_on stops conversion and powers the converter down.
// (RQ14) Wait mode leaves converter operation unaffected.
// (RQ15) Halt mode disables the converter; results after wake-up need a settling interval.
// (RQ16) Software writes channel_select before starting a conversion.
// (RQ17) channel_select decodes as a plain binary index, zero to fifteen.
// (RQ18) Any write to the control/status register clears the completion flag; a same-cycle completion wins here except on a channel-change restart.
// (RQ19) High byte holds bits nine to two; low byte holds bits one, zero, rest zero.
// (RQ20) Each conversion samples first, then runs fixed successive-approximation steps.
// (RQ21) After reset: converter off, flag clear, channel zero, results zero.
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

// =====================================================
// Control/status field positions
`define SAC_CSR_COMPLETE    7
`define SAC_CSR_SPEED       6
`define SAC_CSR_ON          5
`define SAC_CSR_CHAN_HI     3
`define SAC_CSR_CHAN_LO     0

// =====================================================
// Widths and reset values
`define SAC_RES_W           10
`define SAC_CHAN_W          4
`define SAC_CHAN_N          16
`define SAC_BYTE_RST        8'h00
`define SAC_CHAN_RST        4'h0
`define SAC_SEL_RST         16'h0000
`define SAC_RES_RST         10'h000
`define SAC_RES_FULL        10'h3ff
`define SAC_RES_MSB_CODE    10'h200
`define SAC_MSB_IDX         4'h9
`define SAC_LOW_PAD         6'h00

// =====================================================
// Timing counts
`define SAC_DIV_SLOW_LAST   2'h3
`define SAC_DIV_FAST_LAST   2'h1
`define SAC_SAMPLE_LAST     2'h2

`endif

// file: sac_pkg.sv
package sac_pkg;

  // =====================================================
  // Sequencer states
  typedef enum logic [1:0] {
    SAC_IDLE    = 2'b00,
    SAC_SAMPLE  = 2'b01,
    SAC_CONVERT = 2'b10
  } sac_state_e;

endpackage : sac_pkg

// file: sac_tick_gen.sv
`timescale 1ns/1ns
`include "sac_consts.svh"

module sac_tick_gen (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // Control
  input  wire logic enable,
  input  wire logic speed,
  // Converter clock tick
  output logic      tick_q
);

  logic [1:0] cnt_q;
  logic [1:0] last;

  assign last = speed ? `SAC_DIV_FAST_LAST : `SAC_DIV_SLOW_LAST;

  // =====================================================
  // Divider
  always_ff @(posedge ref_clk) begin
    if (reset || !enable) begin
      cnt_q  <= 2'h0;
      tick_q <= 1'b0;
    end else if (cnt_q == last) begin
      cnt_q  <= 2'h0;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 2'h1;
      tick_q <= 1'b0;
    end
  end

  chk_tick_spacing : assert property (@(posedge ref_clk) disable iff (reset)
    tick_q |=> !tick_q) else $error("Tick not single cycle");

endmodule : sac_tick_gen

// file: sac_sar_core.sv
`timescale 1ns/1ns
`include "sac_consts.svh"

module sac_sar_core (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  // Sequencing
  input  wire logic                  start,
  input  wire logic                  abort,
  input  wire logic                  step,
  // Comparator and range detect
  input  wire logic                  cmp_above,
  input  wire logic                  force_high,
  input  wire logic                  force_low,
  // Results
  output logic [`SAC_RES_W-1:0]      dac_code_q,
  output logic [`SAC_RES_W-1:0]      result_q,
  output logic                       done_q
);

  logic       busy_q;
  logic [3:0] idx_q;
  logic [`SAC_RES_W-1:0] final_code;

  always_comb begin
    final_code = dac_code_q;
    final_code[0] = cmp_above;
  end

  // =====================================================
  // Bit trials
  always_ff @(posedge ref_clk) begin
    if (reset || abort) begin
      busy_q     <= 1'b0;
      idx_q      <= 4'h0;
      dac_code_q <= `SAC_RES_RST;
    end else if (start) begin
      busy_q     <= 1'b1;
      idx_q      <= `SAC_MSB_IDX;
      dac_code_q <= `SAC_RES_MSB_CODE; // RQ20
    end else if (busy_q && step) begin
      dac_code_q[idx_q] <= cmp_above;
      if (idx_q != 4'h0) begin
        dac_code_q[idx_q - 4'h1] <= 1'b1;
        idx_q <= idx_q - 4'h1;
      end else begin
        busy_q <= 1'b0;
      end
    end
  end

  // =====================================================
  // Result with saturation
  always_ff @(posedge ref_clk) begin
    if (reset || abort) begin
      done_q   <= 1'b0;
      result_q <= `SAC_RES_RST;
    end else if (busy_q && step && idx_q == 4'h0) begin
      done_q <= 1'b1;
      if (force_high)
        result_q <= `SAC_RES_FULL; // RQ3
      else if (force_low)
        result_q <= `SAC_RES_RST; // RQ4
      else
        result_q <= final_code; // RQ1
    end else begin
      done_q <= 1'b0;
    end
  end

  chk_sat_high : assert property (@(posedge ref_clk) disable iff (reset) // RQ3
    (busy_q && step && idx_q == 4'h0 && force_high && !abort) |=> result_q == `SAC_RES_FULL)
    else $error("No saturation above high reference");

  chk_sat_low : assert property (@(posedge ref_clk) disable iff (reset) // RQ4
    (busy_q && step && idx_q == 4'h0 && force_low && !force_high && !abort) |=> result_q == `SAC_RES_RST)
    else $error("No zero below low reference");

endmodule : sac_sar_core

// file: sac_analog_model.sv
`timescale 1ns/1ns
`include "sac_consts.svh"

module sac_analog_model (
  // Clock
  input  wire logic                                   ref_clk,
  // Converter drive
  input  wire logic [`SAC_CHAN_N-1:0]                 analog_input_select_q,
  input  wire logic [`SAC_RES_W-1:0]                  dac_code_q,
  // Input levels per channel
  input  wire logic [`SAC_CHAN_N-1:0][`SAC_RES_W-1:0] level,
  input  wire logic [`SAC_CHAN_N-1:0]                 over,
  input  wire logic [`SAC_CHAN_N-1:0]                 under,
  // Comparator and range detect
  output logic                                        cmp_above,
  output logic                                        above_high_reference,
  output logic                                        below_low_reference
);
  // ==========================================
  // Unselected inputs give a changing pattern
  logic toggle_q = 1'b0;
  always_ff @(posedge ref_clk) begin
    toggle_q <= ~toggle_q;
  end

  // ==========================================
  // Selected input and comparator
  always_comb begin
    cmp_above = toggle_q;
    above_high_reference = toggle_q;
    below_low_reference = ~toggle_q;
    for (int i = 0; i < `SAC_CHAN_N; i++) begin
      if (analog_input_select_q[i]) begin
        cmp_above = (level[i] >= dac_code_q);
        above_high_reference = over[i];
        below_low_reference = under[i];
      end
    end
  end
endmodule : sac_analog_model

// file: tb_top.sv
`timescale 1ns/1ns
`include "sac_consts.svh"

module tb_top;
  // ==========================================
  // Stimulus and observed signals
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic csr_wr = 1'b0;
  logic [7:0] csr_wdata = 8'h00;
  logic result_high_rd = 1'b0;
  logic halt_mode = 1'b0;
  logic [15:0][9:0] level;
  logic [15:0] over = 16'h4000;
  logic [15:0] under = 16'h8000;
  logic cmp_above, above_high_reference, below_low_reference;
  logic conv_complete_q, speed_q, converter_on_q, sample_hold_q, converter_power_q;
  logic [3:0] channel_select_q;
  logic [7:0] result_high_byte_q, result_low_byte_q;
  logic [15:0] analog_input_select_q;
  logic [9:0] dac_code_q;
  int fail_count = 0;
  int total_checks = 0;
  int wait_n;

  always #10 ref_clk = ~ref_clk;

  sac_conv_ctrl uut (.ref_clk, .reset, .csr_wr, .csr_wdata, .result_high_rd, .halt_mode,
    .cmp_above, .above_high_reference, .below_low_reference, .conv_complete_q, .speed_q,
    .converter_on_q, .channel_select_q, .result_high_byte_q, .result_low_byte_q,
    .analog_input_select_q, .sample_hold_q, .converter_power_q, .dac_code_q);

  sac_analog_model front (.ref_clk, .analog_input_select_q, .dac_code_q, .level, .over,
    .under, .cmp_above, .above_high_reference, .below_low_reference);

  // ==========================================
  // Checks and verdict
  task automatic check_bit(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
      fail_count++;
    end
  endtask : check_bit

  task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
      fail_count++;
    end
  endtask : check_val

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  // ==========================================
  // Access tasks
  task automatic csr_write(input logic [7:0] d);
    @(posedge ref_clk);
    csr_wr <= 1'b1;
    csr_wdata <= d;
    @(posedge ref_clk);
    csr_wr <= 1'b0;
    #1;
  endtask : csr_write

  task automatic read_high();
    @(posedge ref_clk);
    result_high_rd <= 1'b1;
    @(posedge ref_clk);
    result_high_rd <= 1'b0;
    #1;
  endtask : read_high

  task automatic wait_complete();
    wait_n = 0;
    while (conv_complete_q !== 1'b1 && wait_n < 200) begin
      @(posedge ref_clk);
      #1;
      wait_n++;
    end
    if (wait_n == 200) begin
      $display("wrong value completion expected 1 seen %0h", conv_complete_q);
      fail_count++;
      print_verdict();
    end
  endtask : wait_complete

  task automatic get_result(input logic [9:0] exp);
    wait_complete();
    check_val("low byte", {8'h00, 6'h00, exp[1:0]}, {8'h00, result_low_byte_q});
    check_val("high byte", {8'h00, exp[9:2]}, {8'h00, result_high_byte_q});
    read_high();
    check_bit("flag after read", 1'b0, conv_complete_q);
  endtask : get_result

  task automatic quiet_off();
    int n;
    n = 0;
    @(posedge ref_clk);
    #1;
    check_bit("power", 1'b0, converter_power_q);
    check_val("input select", 16'h0000, analog_input_select_q);
    check_bit("sample hold", 1'b0, sample_hold_q);
    check_val("trial code", 16'h0000, {6'h00, dac_code_q});
    repeat (120) begin
      @(posedge ref_clk);
      #1;
      if (conv_complete_q !== 1'b0) n++;
    end
    check_val("completions", 16'h0000, n[15:0]);
  endtask : quiet_off

  // ==========================================
  // Main sequence
  initial begin
    logic [3:0] ch;
    for (int i = 0; i < 16; i++) level[i] = 10'(i * 65);
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    #1;
    check_val("reset fields", 16'h0000, {8'h00, conv_complete_q, speed_q, converter_on_q,
      converter_power_q, channel_select_q});
    check_val("reset result", 16'h0000, {result_high_byte_q, result_low_byte_q});
    check_val("reset select", 16'h0000, analog_input_select_q);
    for (int i = 0; i < 16; i++) begin
      ch = 4'(i);
      csr_write({ch[2], ch[0], 1'b1, ch[1], ch});
      check_bit("flag after write", 1'b0, conv_complete_q);
      check_val("fields", {10'h000, ch[0], 1'b1, ch}, {10'h000, speed_q, converter_on_q,
        channel_select_q});
      @(posedge ref_clk);
      #1;
      check_val("input select", 16'h0001 << ch, analog_input_select_q);
      check_bit("power", 1'b1, converter_power_q);
      @(posedge ref_clk);
      #1;
      check_bit("sample hold", 1'b1, sample_hold_q);
      get_result(over[i] ? 10'h3ff : under[i] ? 10'h000 : level[i]);
    end
    @(posedge ref_clk);
    under <= 16'h0000;
    get_result(level[15]);
    check_bit("fast period", 1'b1, wait_n >= 20 && wait_n <= 26);
    wait_complete();
    csr_write(8'h6f);
    check_bit("flag after write", 1'b0, conv_complete_q);
    get_result(level[15]);
    csr_write(8'h0f);
    quiet_off();
    @(posedge ref_clk);
    halt_mode <= 1'b1;
    csr_write(8'h21);
    quiet_off();
    @(posedge ref_clk);
    halt_mode <= 1'b0;
    get_result(level[1]);
    get_result(level[1]);
    check_bit("slow period", 1'b1, wait_n >= 46 && wait_n <= 52);
    print_verdict();
  end
endmodule : tb_top
